// ---- ncd_pkg.sv ----
// constants and types for the nibble cpu datapath
package ncd_pkg;
  // instruction commands from the sequencer
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_LDA = 5'h01, OP_ADD = 5'h02, OP_ADC = 5'h03,
    OP_SUB = 5'h04, OP_SBC = 5'h05, OP_CMP = 5'h06, OP_RLC = 5'h07,
    OP_RRC = 5'h08, OP_CCC = 5'h09, OP_CCS = 5'h0a, OP_SCF = 5'h0b,
    OP_SGF = 5'h0c, OP_CGF = 5'h0d, OP_TGF = 5'h0e, OP_LDL = 5'h0f,
    OP_LDH = 5'h10, OP_STSP = 5'h11, OP_LDSP = 5'h12, OP_CALL = 5'h13,
    OP_RET = 5'h14, OP_RTI = 5'h15, OP_INTA = 5'h16, OP_BR = 5'h17,
    OP_DPL = 5'h18, OP_DPM = 5'h19, OP_DPH = 5'h1a, OP_DPI = 5'h1b,
    OP_PSET = 5'h1c, OP_PCLR = 5'h1d, OP_PTST = 5'h1e, OP_EI = 5'h1f
  } ncd_op_t;
  // register port offsets
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_FLAGS = 2'h1;
  localparam logic [1:0] REG_SP = 2'h2;
  localparam logic [1:0] REG_ACC = 2'h3;
  // control register fields
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_SLEEP_BIT = 3;
  // reset values and the first phase code
  localparam logic SF_RESET = 1'b1;
  localparam logic [2:0] RATE_RESET = 3'h0;
  localparam logic [3:0] PHASE_FIRST = 4'h1;
  localparam logic [3:0] PHASE_LAST = 4'h8;
  // time base: 22 stages, tick tap is TB_TAP_LO plus the rate code
  localparam int TB_W = 22;
  localparam logic [4:0] TB_TAP_LO = 5'h08;
  // interrupt vectors: VEC_BASE + VEC_STEP * source
  localparam logic [11:0] VEC_BASE = 12'h002;
  localparam logic [11:0] VEC_STEP = 12'h002;
  // number of port 4 pins reachable by the low pointer
  localparam logic [3:0] PORT4_PINS = 4'h2;
endpackage

// ---- ncd_datapath.sv ----
// accumulator, flags, alu, pointers, stack, phases and time base
//
// Summary of operation
// - four-bit accumulator is alu source and destination
// - four flags pushed on interrupt, restored by interrupt return
// - addition carry out sets carry flag
// - subtract and compare: borrow clears carry flag
// - copy carry to branch flag, then clear/set
// - zero flag follows alu result being zero
// - reset forces branch condition flag high
// - branch taken only when branch flag high
// - user flag changed only by its instructions and interrupt return
// - only carry flag feeds the alu
// - rotate left through carry
// - rotate right through carry
// - two pointer registers, data or ram address
// - low pointer selects port 4 pin 0-1
// - stack pointer not reset, software loads it
// - stack pointer down on entry, up on return
// - accumulator to and from stack pointer
// - twelve-bit rom table pointer
// - sleep stops clock, oscillator pin held high
// - instruction cycle is four phase signals
// - 22-stage time base from base clock
// - tick at one of eight time base rates
// - interrupt pushes pc and flags, loads vector
// - interrupt return restores pc, flags, enable
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
module ncd_datapath (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // instruction command from the sequencer
  input wire logic op_valid,
  input wire ncd_pkg::ncd_op_t op_code,
  input wire logic [3:0] op_data,
  input wire logic [11:0] op_target,
  input wire logic [11:0] pc_next,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [3:0] reg_rdata,
  // pins
  input wire logic wake_n_pin,
  input wire logic [1:0] port4_pin,
  output logic osc_output_pin,
  output logic [3:0] phase_signals,
  // datapath state
  output logic [3:0] acc,
  output logic [3:0] flags,
  output logic [3:0] ptr_high,
  output logic [3:0] ptr_low,
  output logic [11:0] rom_table_pointer,
  // program counter control
  output logic pc_load,
  output logic [11:0] pc_out,
  output logic int_enable,
  // port bit strobes
  output logic port_bit_set,
  output logic port_bit_clear,
  output logic port_bit_sel,
  // time base
  output logic periodic_tick_interrupt,
  output logic [21:0] time_base
);
  import ncd_pkg::*;

  logic [3:0] phase_ff; // one-hot phase
  logic sleep_ff; // clock stopped
  logic sleep_req_ff; // software asked for sleep
  logic [2:0] rate_ff; // tick rate code
  logic wake_s1_ff, wake_s2_ff, wake_s3_ff; // wake pin synchroniser and edge
  logic [1:0] p4_s1_ff, p4_s2_ff; // port pin synchroniser
  logic [TB_W-1:0] tb_ff; // time base counter
  logic tick_ff;
  logic osc_ff;
  logic [3:0] acc_ff;
  logic cf_ff, zf_ff, sf_ff, gf_ff;
  logic [3:0] ph_ff, pl_ff; // pointer pair
  logic [3:0] sp_ff; // stack level
  logic [11:0] pc_stk [16]; // return addresses
  logic [3:0] flag_stk [16]; // saved flags
  logic [11:0] dp_ff;
  logic pc_load_ff, ei_ff;
  logic [11:0] pc_out_ff;
  logic pset_ff, pclr_ff;
  logic [3:0] rdata_ff;
  logic op_take; // command accepted this cycle
  logic [3:0] nxt_acc;
  logic nxt_cf, nxt_zf, alu_wr, alu_op;
  logic [4:0] sum5, dif5;
  logic [TB_W-1:0] tap_mask;
  logic wake_edge;

  // vector address of an interrupt source
  function automatic logic [11:0] vec_of(input logic [2:0] src);
    vec_of = VEC_BASE + VEC_STEP * {9'h000, src};
  endfunction

  // commands only land at the end of an instruction cycle
  assign op_take = op_valid && phase_ff[3] && !sleep_ff;
  assign wake_edge = wake_s3_ff && !wake_s2_ff;

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wake_s1_ff <= 1'b1;
      wake_s2_ff <= 1'b1;
      wake_s3_ff <= 1'b1;
      p4_s1_ff <= 2'h0;
      p4_s2_ff <= 2'h0;
    end else begin
      wake_s1_ff <= wake_n_pin;
      wake_s2_ff <= wake_s1_ff;
      wake_s3_ff <= wake_s2_ff;
      p4_s1_ff <= port4_pin;
      p4_s2_ff <= p4_s1_ff;
    end
  end

  // four phases
  // phases rotate; sleep only starts at the last phase so a cycle never splits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= PHASE_LAST;
    end else if (!sleep_ff) begin
      phase_ff <= {phase_ff[2:0], phase_ff[3]};
    end
  end

  // sleep control
  // set of the request wins over its consumption in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sleep_req_ff <= 1'b0;
      sleep_ff <= 1'b0;
      rate_ff <= RATE_RESET;
      osc_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == REG_CTRL) begin
        rate_ff <= reg_wdata[CTRL_RATE_LSB +: 3];
      end
      if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_SLEEP_BIT]) begin
        sleep_req_ff <= 1'b1;
      end else if (sleep_req_ff && phase_ff[3] && !sleep_ff) begin
        sleep_req_ff <= 1'b0;
      end
      if (sleep_ff && wake_edge) begin
        sleep_ff <= 1'b0;
      end else if (sleep_req_ff && phase_ff[3]) begin
        sleep_ff <= 1'b1;
      end
      // oscillator pin parks high while stopped, else shows the phase clock
      osc_ff <= sleep_ff | phase_ff[1] | phase_ff[2];
    end
  end

  // time base
  // cleared during sleep, counts one per base clock otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tb_ff <= '0;
    end else if (sleep_ff) begin
      tb_ff <= '0;
    end else begin
      tb_ff <= tb_ff + 22'h000001;
    end
  end

  // tick tap
  // tick fires as the tapped stage is about to roll over
  assign tap_mask = (22'h000001 << (TB_TAP_LO + {2'h0, rate_ff})) - 22'h000001;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= !sleep_ff && ((tb_ff & tap_mask) == tap_mask);
    end
  end

  // carry only
  // alu; the carry flag is the only flag feeding the arithmetic
  always_comb begin
    sum5 = {1'b0, acc_ff} + {1'b0, op_data} +
      {4'h0, (op_code == OP_ADC) & cf_ff};
    dif5 = {1'b0, acc_ff} - {1'b0, op_data} -
      {4'h0, (op_code == OP_SBC) & ~cf_ff};
    nxt_acc = acc_ff;
    nxt_cf = cf_ff;
    alu_wr = 1'b1;
    alu_op = 1'b1;
    case (op_code)
      OP_ADD, OP_ADC: begin
        nxt_acc = sum5[3:0];
        nxt_cf = sum5[4];
      end
      OP_SUB, OP_SBC: begin
        nxt_acc = dif5[3:0];
        nxt_cf = ~dif5[4];
      end
      // compare keeps the accumulator, flags only
      OP_CMP: begin
        nxt_cf = ~dif5[4];
        alu_wr = 1'b0;
      end
      OP_RLC: begin
        nxt_acc = {acc_ff[2:0], cf_ff};
        nxt_cf = acc_ff[3];
      end
      OP_RRC: begin
        nxt_acc = {cf_ff, acc_ff[3:1]};
        nxt_cf = acc_ff[0];
      end
      OP_LDA: nxt_acc = op_data;
      OP_LDSP: nxt_acc = sp_ff;
      default: begin
        alu_wr = 1'b0;
        alu_op = 1'b0;
      end
    endcase
    nxt_zf = (op_code == OP_CMP) ? (dif5[3:0] == 4'h0) : (nxt_acc == 4'h0);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_ff <= 4'h0;
    end else if (op_take && alu_wr) begin
      acc_ff <= nxt_acc;
    end
  end

  // flags; the sequencer never sends two flag sources at once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cf_ff <= 1'b0;
      zf_ff <= 1'b0;
      sf_ff <= SF_RESET;
      gf_ff <= 1'b0;
    end else if (op_take) begin
      if (alu_op) begin
        cf_ff <= nxt_cf;
        zf_ff <= nxt_zf;
        // add reports no-carry, subtract reports no-borrow, loads report 1
        sf_ff <= (op_code == OP_ADD || op_code == OP_ADC) ? ~sum5[4] :
          (op_code == OP_LDA || op_code == OP_LDSP) ? 1'b1 : nxt_cf;
      end
      case (op_code)
        OP_CCC, OP_CCS: begin
          sf_ff <= cf_ff;
          cf_ff <= (op_code == OP_CCS);
        end
        OP_SCF: cf_ff <= 1'b1;
        OP_SGF: gf_ff <= 1'b1;
        OP_CGF: gf_ff <= 1'b0;
        OP_TGF: sf_ff <= gf_ff;
        OP_PTST: sf_ff <= (pl_ff < PORT4_PINS) && p4_s2_ff[pl_ff[0]];
        OP_RTI: {gf_ff, sf_ff, zf_ff, cf_ff} <= flag_stk[sp_ff];
        // interrupt entry forces the branch flag high
        OP_INTA: sf_ff <= 1'b1;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_ff <= 4'h0;
      pl_ff <= 4'h0;
    end else if (op_take) begin
      if (op_code == OP_LDL) begin
        pl_ff <= op_data;
      end
      if (op_code == OP_LDH) begin
        ph_ff <= op_data;
      end
    end
  end

  // stack level left unreset
  // stack storage and level carry no reset on purpose: software loads them
  always_ff @(posedge clk) begin
    if (op_take) begin
      case (op_code)
        OP_STSP: sp_ff <= acc_ff;
        OP_CALL, OP_INTA: begin
          sp_ff <= sp_ff - 4'h1;
          pc_stk[sp_ff - 4'h1] <= pc_next;
          flag_stk[sp_ff - 4'h1] <= {gf_ff, sf_ff, zf_ff, cf_ff};
        end
        OP_RET, OP_RTI: sp_ff <= sp_ff + 4'h1;
        default: begin
        end
      endcase
    end
  end

  // rom table pointer
  // loaded one nibble at a time from the accumulator, stepped by OP_DPI
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dp_ff <= 12'h000;
    end else if (op_take) begin
      case (op_code)
        OP_DPL: dp_ff[3:0] <= acc_ff;
        OP_DPM: dp_ff[7:4] <= acc_ff;
        OP_DPH: dp_ff[11:8] <= acc_ff;
        OP_DPI: dp_ff <= dp_ff + 12'h001;
        default: begin
        end
      endcase
    end
  end

  // program counter control and interrupt enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_load_ff <= 1'b0;
      pc_out_ff <= 12'h000;
      ei_ff <= 1'b0;
    end else begin
      pc_load_ff <= 1'b0;
      if (op_take) begin
        case (op_code)
          OP_BR: begin
            pc_load_ff <= sf_ff;
            pc_out_ff <= op_target;
          end
          OP_CALL: begin
            pc_load_ff <= 1'b1;
            pc_out_ff <= op_target;
          end
          OP_RET: begin
            pc_load_ff <= 1'b1;
            pc_out_ff <= pc_stk[sp_ff];
          end
          OP_RTI: begin
            pc_load_ff <= 1'b1;
            pc_out_ff <= pc_stk[sp_ff];
            ei_ff <= 1'b1;
          end
          OP_INTA: begin
            pc_load_ff <= 1'b1;
            pc_out_ff <= vec_of(op_data[2:0]);
            ei_ff <= 1'b0;
          end
          OP_EI: ei_ff <= op_data[0];
          default: begin
          end
        endcase
      end
    end
  end

  // port pin strobes
  // pointer values at or above the pin count give no strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pset_ff <= 1'b0;
      pclr_ff <= 1'b0;
    end else begin
      pset_ff <= op_take && op_code == OP_PSET && pl_ff < PORT4_PINS;
      pclr_ff <= op_take && op_code == OP_PCLR && pl_ff < PORT4_PINS;
    end
  end

  // register reads; data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 4'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: rdata_ff <= {sleep_req_ff, rate_ff};
        REG_FLAGS: rdata_ff <= {gf_ff, sf_ff, zf_ff, cf_ff};
        REG_SP: rdata_ff <= sp_ff;
        default: rdata_ff <= acc_ff;
      endcase
    end else begin
      rdata_ff <= 4'h0;
    end
  end

  assign reg_rdata = rdata_ff;
  assign osc_output_pin = osc_ff;
  assign phase_signals = phase_ff;
  assign acc = acc_ff;
  assign flags = {gf_ff, sf_ff, zf_ff, cf_ff};
  assign ptr_high = ph_ff;
  assign ptr_low = pl_ff;
  assign rom_table_pointer = dp_ff;
  assign pc_load = pc_load_ff;
  assign pc_out = pc_out_ff;
  assign int_enable = ei_ff;
  assign port_bit_set = pset_ff;
  assign port_bit_clear = pclr_ff;
  assign port_bit_sel = pl_ff[0];
  assign periodic_tick_interrupt = tick_ff;
  assign time_base = tb_ff;

  // checks
  sequence s_cycle;
    phase_ff == 4'h2 ##1 phase_ff == 4'h4 ##1 phase_ff == 4'h8;
  endsequence
  property p_phase;
    // sleep freezes the ring on the first phase, so only a running first phase counts
    @(posedge clk) disable iff (!nrst) (phase_ff == 4'h1 && !sleep_ff) |=> s_cycle;
  endproperty
  a_phase: assert property (p_phase) else $error("phase order broken");
  property p_add_cf;
    @(posedge clk) disable iff (!nrst) (op_take && op_code == OP_ADD) |=>
      cf_ff == (({1'b0, $past(acc_ff)} + {1'b0, $past(op_data)}) > 5'h0f);
  endproperty
  a_add_cf: assert property (p_add_cf) else $error("add carry wrong");
  property p_sub_cf;
    @(posedge clk) disable iff (!nrst) (op_take && op_code == OP_SUB) |=>
      cf_ff == ($past(acc_ff) >= $past(op_data));
  endproperty
  a_sub_cf: assert property (p_sub_cf) else $error("borrow wrong");
  property p_zero;
    @(posedge clk) disable iff (!nrst)
      (op_take && op_code inside {OP_ADD, OP_SUB, OP_RLC, OP_RRC}) |=> zf_ff == (acc_ff == 4'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_rlc;
    @(posedge clk) disable iff (!nrst) (op_take && op_code == OP_RLC) |=>
      acc_ff == {$past(acc_ff[2:0]), $past(cf_ff)} && cf_ff == $past(acc_ff[3]);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left wrong");
  property p_ccc;
    @(posedge clk) disable iff (!nrst) (op_take && op_code == OP_CCC) |=>
      sf_ff == $past(cf_ff) && !cf_ff;
  endproperty
  a_ccc: assert property (p_ccc) else $error("copy carry clear wrong");
  property p_gf;
    @(posedge clk) disable iff (!nrst)
      !(op_take && op_code inside {OP_SGF, OP_CGF, OP_RTI}) |=> $stable(gf_ff);
  endproperty
  a_gf: assert property (p_gf) else $error("user flag disturbed");
  property p_sp_call;
    @(posedge clk) disable iff (!nrst) (op_take && op_code == OP_CALL) |=>
      sp_ff == $past(sp_ff) - 4'h1 ##1 pc_load_ff == 1'b0;
  endproperty
  a_sp_call: assert property (p_sp_call) else $error("stack level wrong");
  property p_osc;
    @(posedge clk) disable iff (!nrst) sleep_ff [*2] |-> osc_ff;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator pin not high");
endmodule

// ---- ncd_seq_model.sv ----
// sequencer model: feeds commands to the datapath
module ncd_seq_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // datapath feedback
  input wire logic [3:0] phase_signals,
  input wire logic pc_load,
  input wire logic [11:0] pc_out,
  // command port
  output logic op_valid,
  output ncd_pkg::ncd_op_t op_code,
  output logic [3:0] op_data,
  output logic [11:0] op_target,
  output logic [11:0] pc_next
);
  timeunit 1ns;
  timeprecision 1ps;
  import ncd_pkg::*;
  // sequencer pc and idle edges before a raise
  logic [11:0] pc_ff;
  int lag = 0;
  assign pc_next = pc_ff + 12'h001;
  // taken command steps the pc, a datapath load wins
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_ff <= 12'h000;
    end else if (pc_load === 1'b1) begin
      pc_ff <= pc_out;
    end else if (op_valid && phase_signals == PHASE_LAST) begin
      pc_ff <= pc_next;
    end
  end
  // idle bus at start
  initial begin
    op_valid = 1'b0;
    op_code = OP_NOP;
    op_data = 4'h0;
    op_target = 12'h000;
  end
  // hold a command until an edge in the last phase takes it
  task automatic issue(input ncd_op_t c, input logic [3:0] d, input logic [11:0] t,
                       output bit ok);
    ok = 1'b0;
    repeat (lag + 1) @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_data <= d;
    op_target <= t;
    for (int k = 0; k < 12 && !ok; k++) begin
      @(posedge clk);
      ok = (phase_signals === PHASE_LAST);
    end
    // released fields turn to garbage, nobody may rely on them
    op_valid <= 1'b0;
    op_code <= ncd_op_t'(~c);
    op_data <= ~d;
    op_target <= ~t;
  endtask
endmodule

// ---- ncd_datapath_tb.sv ----
// self-checking bench for the nibble cpu datapath
module ncd_datapath_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ncd_pkg::*;
  // clock, reset, register port and pins
  logic clk;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, wake_n_pin = 1'b1;
  logic [1:0] reg_addr = 2'h0, port4_pin = 2'h2;
  logic [3:0] reg_wdata = 4'h0, reg_rdata, rd;
  // datapath outputs and command port
  logic op_valid, pc_load, int_enable, osc_output_pin, port_bit_set, port_bit_clear;
  logic port_bit_sel, periodic_tick_interrupt;
  ncd_op_t op_code;
  logic [3:0] op_data, acc, flags, ptr_high, ptr_low, phase_signals;
  logic [11:0] op_target, pc_next, pc_out, rom_table_pointer, ret;
  logic [21:0] time_base;
  // scoreboard and pulse counts
  int mismatches = 0, num_checks = 0, n_ld = 0, n_set = 0, n_clr = 0;

  ncd_datapath i_ncd_datapath (.clk, .nrst, .op_valid, .op_code, .op_data, .op_target,
    .pc_next, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wake_n_pin,
    .port4_pin, .osc_output_pin, .phase_signals, .acc, .flags, .ptr_high, .ptr_low,
    .rom_table_pointer, .pc_load, .pc_out, .int_enable, .port_bit_set, .port_bit_clear,
    .port_bit_sel, .periodic_tick_interrupt, .time_base);
  ncd_seq_model i_ncd_seq_model (.clk, .nrst, .phase_signals, .pc_load, .pc_out,
    .op_valid, .op_code, .op_data, .op_target, .pc_next);

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // count one-cycle pulses so their timing need not be guessed
  always @(posedge clk) begin
    if (pc_load === 1'b1) n_ld <= n_ld + 1;
    if (port_bit_set === 1'b1) n_set <= n_set + 1;
    if (port_bit_clear === 1'b1) n_clr <= n_clr + 1;
  end
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // compare with four-state equality
  // wide enough for the longest joined compare, so no field is cut off
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // a wait that ran out ends the run
  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("mismatch at %0t: wait ran out", $time);
      stop_test();
    end
  endtask
  // one command, then let its pulses land
  task automatic op(input ncd_op_t c, input logic [3:0] d = 4'h0, input logic [11:0] t = 12'h0);
    bit ok;
    i_ncd_seq_model.issue(c, d, t, ok);
    limit(ok ? 0 : 1, 1);
    repeat (3) @(negedge clk);
  endtask
  // register port write and read
  task automatic wr(input logic [1:0] a, input logic [3:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [1:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
  endtask
  task automatic t_reset;
    @(negedge clk);
    rdr(REG_FLAGS);
    chk(rd, 4'h4, "reset flags");
    @(negedge clk);
    chk(reg_rdata, 4'h0, "rdata one cycle");
    wr(REG_ACC, 4'ha);
    rdr(REG_ACC);
    chk(rd, 4'h0, "acc read only");
    $display("t_reset done");
  endtask
  // load a, preset carry, run c with b; cz is {carry, zero}
  task automatic alu(input ncd_op_t c, input logic [3:0] a, b, input logic ci,
                     input logic [3:0] r, input logic [1:0] cz);
    logic bf;
    bf = (c == OP_ADD || c == OP_ADC) ? ~cz[1] : cz[1];
    op(OP_LDA, a);
    op(ci ? OP_SCF : OP_CCC);
    op(c, b);
    chk(acc, r, "alu result");
    chk(flags, {1'b1, bf, cz[0], cz[1]}, "alu flags");
  endtask
  task automatic t_alu;
    op(OP_SGF);
    alu(OP_ADD, 4'h3, 4'h4, 1'b1, 4'h7, 2'h0);
    alu(OP_ADD, 4'h7, 4'hf, 1'b0, 4'h6, 2'h2);
    alu(OP_ADD, 4'h8, 4'h8, 1'b0, 4'h0, 2'h3);
    alu(OP_ADC, 4'h7, 4'h8, 1'b1, 4'h0, 2'h3);
    alu(OP_ADC, 4'h7, 4'h8, 1'b0, 4'hf, 2'h0);
    alu(OP_SUB, 4'h8, 4'h4, 1'b0, 4'h4, 2'h2);
    alu(OP_SUB, 4'h7, 4'hf, 1'b1, 4'h8, 2'h0);
    alu(OP_SBC, 4'h9, 4'h9, 1'b0, 4'hf, 2'h0);
    alu(OP_SBC, 4'h9, 4'h9, 1'b1, 4'h0, 2'h3);
    alu(OP_CMP, 4'h7, 4'hf, 1'b1, 4'h7, 2'h0);
    alu(OP_CMP, 4'h9, 4'h9, 1'b0, 4'h9, 2'h3);
    alu(OP_RLC, 4'h9, 4'h0, 1'b0, 4'h2, 2'h2);
    alu(OP_RLC, 4'h4, 4'h0, 1'b1, 4'h9, 2'h0);
    alu(OP_RRC, 4'h2, 4'h0, 1'b1, 4'h9, 2'h0);
    alu(OP_RRC, 4'h1, 4'h0, 1'b0, 4'h0, 2'h3);
    $display("t_alu done");
  endtask
  task automatic t_flag;
    i_ncd_seq_model.lag = 2;
    op(OP_SCF);
    op(OP_CCC);
    chk({flags[2], flags[0]}, 2'h2, "copy clear");
    op(OP_CCS);
    chk({flags[2], flags[0]}, 2'h1, "copy set");
    op(OP_CCS);
    chk({flags[2], flags[0]}, 2'h3, "copy set");
    op(OP_CGF);
    op(OP_TGF);
    chk(flags[3:2], 2'h0, "user clear");
    op(OP_SGF);
    op(OP_TGF);
    chk(flags[3:2], 2'h3, "user set");
    i_ncd_seq_model.lag = 0;
    $display("t_flag done");
  endtask
  task automatic t_branch;
    int n;
    op(OP_LDA, 4'hf);
    op(OP_ADD, 4'h1);
    n = n_ld;
    op(OP_BR, 4'h0, 12'h123);
    chk(22'(n_ld - n), 22'h0, "branch not taken");
    op(OP_LDA, 4'h1);
    op(OP_BR, 4'h0, 12'h456);
    chk({22'(n_ld - n), pc_out}, {22'h1, 12'h456}, "branch taken");
    $display("t_branch done");
  endtask
  task automatic t_ptr;
    int s, c;
    op(OP_LDH, 4'hd);
    op(OP_LDA, 4'h7);
    op(OP_DPL);
    op(OP_LDA, 4'ha);
    op(OP_DPM);
    op(OP_LDA, 4'hc);
    op(OP_DPH);
    chk(rom_table_pointer, 12'hca7, "table pointer");
    for (int l = 0; l < 3; l++) begin
      op(OP_LDL, 4'(l));
      s = n_set;
      c = n_clr;
      op(OP_PSET);
      op(OP_PCLR);
      op(OP_PTST);
      chk({ptr_high, ptr_low, port_bit_sel}, {4'hd, 4'(l), l[0]}, "pointers");
      chk(22'(n_set - s + 2 * (n_clr - c)), (l < 2) ? 22'h3 : 22'h0, "strobes");
      chk(flags[2], l == 1, "pin test");
    end
    $display("t_ptr done");
  endtask
  task automatic t_stack;
    op(OP_LDA, 4'h6);
    op(OP_STSP);
    rdr(REG_SP);
    chk(rd, 4'h6, "sp from acc");
    ret = pc_next;
    op(OP_CALL, 4'h0, 12'h3c5);
    rdr(REG_SP);
    chk({rd, pc_out}, {4'h5, 12'h3c5}, "call");
    op(OP_RET);
    rdr(REG_SP);
    chk({rd, pc_out}, {4'h6, ret}, "return");
    op(OP_LDA, 4'h0);
    op(OP_LDSP);
    chk(acc, 4'h6, "acc from sp");
    op(OP_EI, 4'h1);
    op(OP_SCF);
    op(OP_SGF);
    op(OP_LDA, 4'h0);
    ret = pc_next;
    op(OP_INTA, 4'h4);
    chk({int_enable, pc_out}, {1'b0, VEC_BASE + VEC_STEP * 12'h4}, "vector");
    op(OP_LDA, 4'h3);
    op(OP_CCC);
    op(OP_CGF);
    op(OP_RTI);
    rdr(REG_SP);
    chk({flags, rd}, 8'hf6, "flags back");
    chk({int_enable, pc_out}, {1'b1, ret}, "rti");
    $display("t_stack done");
  endtask
  task automatic t_time;
    int n;
    logic [21:0] t;
    for (n = 0; n < 8 && phase_signals !== PHASE_FIRST; n++) @(negedge clk);
    limit(n, 8);
    t = time_base;
    for (int k = 0; k < 8; k++) begin
      chk(phase_signals, 4'h1 << (k % 4), "phase");
      chk(time_base, t + 22'(k), "time base");
      @(negedge clk);
    end
    for (int r = 0; r < 8; r++) begin
      wr(REG_CTRL, 4'(r));
      rdr(REG_CTRL);
      chk(rd, 4'(r), "rate");
      for (int j = 0; j < 2 && r < 6; j++) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (periodic_tick_interrupt !== 1'b1 && n < 40000);
        limit(n, 40000);
      end
      if (r < 6) chk(22'(n), 22'(1 << (8 + r)), "tick period");
    end
    $display("t_time done");
  endtask
  task automatic t_sleep;
    int n;
    wr(REG_CTRL, 4'h8);
    repeat (8) @(negedge clk);
    for (n = 0; n < 6; n++) begin
      @(negedge clk);
      // sleep is entered on the edge that rolls the ring over, so it rests on the first phase
      chk({osc_output_pin, phase_signals, time_base}, {1'b1, PHASE_FIRST, 22'h0}, "sleep");
    end
    @(posedge clk);
    wake_n_pin <= 1'b0;
    // hold the pin low until the ring moves on again
    for (n = 0; n < 20 && phase_signals === PHASE_FIRST; n++) @(negedge clk);
    limit(n, 20);
    @(posedge clk);
    wake_n_pin <= 1'b1;
    op(OP_LDA, 4'h2);
    chk(acc, 4'h2, "awake");
    op(OP_LDA, 4'hf);
    op(OP_ADD, 4'h1);
    @(posedge clk);
    nrst <= 1'b0;
    @(negedge clk);
    chk({flags[2:0], acc}, 7'h40, "mid-run reset");
    @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(negedge clk);
    chk(phase_signals, PHASE_FIRST, "phase after reset");
    $display("t_sleep done");
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_alu();
    t_flag();
    t_branch();
    t_ptr();
    t_stack();
    t_time();
    t_sleep();
    stop_test();
  end
endmodule
